/* File: cpsr_pkg.sv */
// cpsr_pkg: constants for the copper port status register block.
// assumes a single 40 MHz core clock domain.
package cpsr_pkg;
   localparam logic [7:0] CPSR_ADDR_STATUS = 8'h11;
   localparam logic [7:0] CPSR_ADDR_CTRL = 8'h40;
   localparam logic [7:0] CPSR_ADDR_IRQ_STAT = 8'h41;
   localparam logic [7:0] CPSR_ADDR_IRQ_MASK = 8'h42;
   localparam int CPSR_BIT_SPEED_HI = 15;
   localparam int CPSR_BIT_SPEED_LO = 14;
   localparam int CPSR_BIT_DUPLEX = 13;
   localparam int CPSR_BIT_PAGE = 12;
   localparam int CPSR_BIT_RESOLVED = 11;
   localparam int CPSR_BIT_LINK_RT = 10;
   localparam int CPSR_BIT_TX_PAUSE = 9;
   localparam int CPSR_BIT_RX_PAUSE = 8;
   localparam int CPSR_BIT_XOVER = 6;
   localparam int CPSR_BIT_SLEEP = 4;
   localparam int CPSR_BIT_GLINK = 3;
   localparam int CPSR_BIT_POL = 1;
   localparam int CPSR_BIT_JABBER = 0;
   localparam int CPSR_CTRL_POL_DIS = 0;
   localparam int CPSR_CTRL_XMODE_LO = 1;
   localparam int CPSR_CTRL_XMODE_HI = 2;
   localparam int CPSR_CTRL_AN_EN = 3;
   localparam int CPSR_CTRL_SW_RST = 4;
   localparam int CPSR_NUM_EVT = 3;
   localparam logic [1:0] CPSR_SPEED_1000 = 2'h2;
   localparam logic [1:0] CPSR_SPEED_100 = 2'h1;
   localparam logic [1:0] CPSR_SPEED_10 = 2'h0;
   localparam logic [1:0] CPSR_SPEED_RSVD = 2'h3;
   localparam logic [1:0] CPSR_XMODE_MDI = 2'h0;
   localparam logic [1:0] CPSR_XMODE_MDIX = 2'h1;
   localparam logic [1:0] CPSR_XMODE_RSVD = 2'h2;
   localparam logic [1:0] CPSR_XMODE_AUTO = 2'h3;
   localparam logic [1:0] CPSR_SPEED_RST = 2'h2;
   localparam logic CPSR_XOVER_RST = 1'h1;
   localparam logic [4:0] CPSR_CTRL_RST = 5'h0E;
   typedef enum logic [1:0] {
      CPSR_ST_PAGE, CPSR_ST_LINK, CPSR_ST_SLEEP
   } cpsr_evt_e;
endpackage : cpsr_pkg

/* File: cpsr_sticky.sv */
// cpsr_sticky: one sticky flag; set beats clear in the same cycle.
// assumes set and clear are single-cycle synchronous pulses.
`timescale 1ns/10ps
module cpsr_sticky (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic i_set,
   input wire logic i_clr,
   output logic o_flag
);
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_flag <= 1'b0;
      end else if (i_set) begin
         o_flag <= 1'b1;
      end else if (i_clr) begin
         o_flag <= 1'b0;
      end
   end
endmodule : cpsr_sticky

/* File: cpsr_top.sv */
// cpsr_top: copper port status register with control, irq status and mask.
// assumes the phy core drives the i_phy_* levels and page pulse on i_sys_clk.
// Contract
// - speed reads 10 for 1000, 01 for 100, 00 for 10, never 11.
// - speed, duplex, pause, crossover are only meaningful while resolved is 1.
// - resolved is set on negotiation complete and held 1 while negotiation is off.
// - bit 13 gives duplex, 1 full and 0 half.
// - bit 12 latches on a partner page and holds until cleared.
// - bit 10 follows copper link live, with no latch.
// - bits 9 and 8 mirror tx and rx pause and steer nothing in the device.
// - bit 6 is 1 for mdix and 0 for mdi, following the manual setting, or the phy in auto mode.
// - a new crossover mode takes effect only after a software reset.
// - bit 4 is 1 while the port sleeps for lack of energy.
// - bit 3 gives global link status.
// - bit 1 shows live receive polarity, suppressed by polarity-reversal disable only in 10BASE-T.
// - bit 0 shows live jabber.
// - with reversal disabled, 10BASE-T polarity reads normal.
// - crossover mode 00 mdi, 01 mdix, 11 auto, 10 reserved.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps
module cpsr_top
   import cpsr_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [DATA_W-1:0] o_rdata,
   input wire logic [1:0] i_phy_speed,
   input wire logic i_phy_duplex,
   input wire logic i_phy_an_done,
   input wire logic i_phy_page_rx,
   input wire logic i_phy_link,
   input wire logic i_phy_tx_pause,
   input wire logic i_phy_rx_pause,
   input wire logic i_phy_auto_mdix,
   input wire logic i_phy_sleep,
   input wire logic i_phy_pol_rev,
   input wire logic i_phy_jabber,
   output logic [1:0] o_xover_mode,
   output logic o_pol_rev_dis,
   output logic o_an_enable,
   output logic o_irq
);
   initial begin
      if (ADDR_W < 8 || DATA_W != 16) begin
         $error("cpsr_top: ADDR_W must be >= 8 and DATA_W must be 16");
      end
   end

   logic [1:0] speed_r;
   logic duplex_r;
   logic resolved_r;
   logic tx_pause_r;
   logic rx_pause_r;
   logic xover_r;
   logic page_r;
   logic [4:0] ctrl_r;
   logic [1:0] xmode_act_r;
   logic [CPSR_NUM_EVT-1:0] irq_mask_r;
   logic [CPSR_NUM_EVT-1:0] irq_stat;
   logic [CPSR_NUM_EVT-1:0] irq_set;
   logic [CPSR_NUM_EVT-1:0] irq_clr;
   logic link_d_r;
   logic sleep_d_r;
   logic pol_live;
   logic [DATA_W-1:0] status_word;
   logic rd_status;
   logic wr_ctrl;
   logic wr_irq_stat;
   logic wr_irq_mask;
   logic sw_rst;

   assign rd_status = i_rd && (i_addr == ADDR_W'(CPSR_ADDR_STATUS));
   assign wr_ctrl = i_wr && (i_addr == ADDR_W'(CPSR_ADDR_CTRL));
   assign wr_irq_stat = i_wr && (i_addr == ADDR_W'(CPSR_ADDR_IRQ_STAT));
   assign wr_irq_mask = i_wr && (i_addr == ADDR_W'(CPSR_ADDR_IRQ_MASK));
   // software reset is self-clearing: a write with the bit set
   assign sw_rst = wr_ctrl && i_wdata[CPSR_CTRL_SW_RST];

   // control register; the reset-request bit is never stored
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         ctrl_r <= CPSR_CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= {1'b0, i_wdata[CPSR_CTRL_AN_EN:0]};
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         xmode_act_r <= CPSR_XMODE_AUTO;
      end else if (sw_rst) begin
         // reserved code 10 falls back to auto
         if (i_wdata[CPSR_CTRL_XMODE_HI:CPSR_CTRL_XMODE_LO] == CPSR_XMODE_RSVD) begin
            xmode_act_r <= CPSR_XMODE_AUTO;
         end else begin
            xmode_act_r <= i_wdata[CPSR_CTRL_XMODE_HI:CPSR_CTRL_XMODE_LO];
         end
      end
   end

   assign o_xover_mode = xmode_act_r;
   assign o_pol_rev_dis = ctrl_r[CPSR_CTRL_POL_DIS];
   assign o_an_enable = ctrl_r[CPSR_CTRL_AN_EN];

   // resolved tracks negotiation or forced when off
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || sw_rst) begin
         resolved_r <= 1'b0;
      end else if (!ctrl_r[CPSR_CTRL_AN_EN]) begin
         resolved_r <= 1'b1;
      end else begin
         resolved_r <= i_phy_an_done;
      end
   end

   // resolved fields capture only while resolution holds; retained otherwise
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         speed_r <= CPSR_SPEED_RST;
         duplex_r <= 1'b0;
         tx_pause_r <= 1'b0;
         rx_pause_r <= 1'b0;
      end else if (!ctrl_r[CPSR_CTRL_AN_EN] || i_phy_an_done) begin
         if (i_phy_speed != CPSR_SPEED_RSVD) begin
            speed_r <= i_phy_speed;
         end
         duplex_r <= i_phy_duplex;
         // pause mirrored only, not used here
         tx_pause_r <= i_phy_tx_pause;
         rx_pause_r <= i_phy_rx_pause;
      end
   end

   // manual modes follow setting, auto follows the phy
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         xover_r <= CPSR_XOVER_RST;
      end else begin
         unique case (xmode_act_r)
            CPSR_XMODE_MDI: xover_r <= 1'b0;
            CPSR_XMODE_MDIX: xover_r <= 1'b1;
            default: xover_r <= i_phy_auto_mdix;
         endcase
      end
   end

   // page latch; read clears, new event wins
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || (sw_rst && !i_phy_page_rx)) begin
         page_r <= 1'b0;
      end else if (i_phy_page_rx) begin
         page_r <= 1'b1;
      end else if (rd_status) begin
         page_r <= 1'b0;
      end
   end

   // live polarity; forced normal in 10BASE-T when disabled
   assign pol_live = i_phy_pol_rev &&
      !(ctrl_r[CPSR_CTRL_POL_DIS] && speed_r == CPSR_SPEED_10);

   always_comb begin
      status_word = '0;
      status_word[CPSR_BIT_SPEED_HI:CPSR_BIT_SPEED_LO] = speed_r;
      status_word[CPSR_BIT_DUPLEX] = duplex_r;
      status_word[CPSR_BIT_PAGE] = page_r;
      status_word[CPSR_BIT_RESOLVED] = resolved_r;
      status_word[CPSR_BIT_LINK_RT] = i_phy_link;
      status_word[CPSR_BIT_TX_PAUSE] = tx_pause_r;
      status_word[CPSR_BIT_RX_PAUSE] = rx_pause_r;
      status_word[CPSR_BIT_XOVER] = xover_r;
      status_word[CPSR_BIT_SLEEP] = i_phy_sleep;
      status_word[CPSR_BIT_GLINK] = i_phy_link;
      status_word[CPSR_BIT_POL] = pol_live;
      status_word[CPSR_BIT_JABBER] = i_phy_jabber;
   end

   // event edges for the interrupt logic
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         link_d_r <= 1'b0;
         sleep_d_r <= 1'b0;
      end else begin
         link_d_r <= i_phy_link;
         sleep_d_r <= i_phy_sleep;
      end
   end

   assign irq_set[CPSR_ST_PAGE] = i_phy_page_rx;
   assign irq_set[CPSR_ST_LINK] = i_phy_link ^ link_d_r;
   assign irq_set[CPSR_ST_SLEEP] = i_phy_sleep ^ sleep_d_r;
   assign irq_clr = wr_irq_stat ? i_wdata[CPSR_NUM_EVT-1:0] : '0;

   for (genvar g = 0; g < CPSR_NUM_EVT; g++) begin : g_evt
      cpsr_sticky u_sticky (
         .i_sys_clk(i_sys_clk),
         .i_sys_rst(i_sys_rst),
         .i_set(irq_set[g]),
         .i_clr(irq_clr[g]),
         .o_flag(irq_stat[g])
      );
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         irq_mask_r <= '0;
      end else if (wr_irq_mask) begin
         irq_mask_r <= i_wdata[CPSR_NUM_EVT-1:0];
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_stat & irq_mask_r);
      end
   end

   // read data one cycle after strobe, zero when idle or unmapped
   always_ff @(posedge i_sys_clk) begin
      if (i_sys_rst || !i_rd) begin
         o_rdata <= '0;
      end else begin
         unique case (i_addr)
            ADDR_W'(CPSR_ADDR_STATUS): o_rdata <= status_word;
            ADDR_W'(CPSR_ADDR_CTRL): o_rdata <= DATA_W'(ctrl_r);
            ADDR_W'(CPSR_ADDR_IRQ_STAT): o_rdata <= DATA_W'(irq_stat);
            ADDR_W'(CPSR_ADDR_IRQ_MASK): o_rdata <= DATA_W'(irq_mask_r);
            default: o_rdata <= '0;
         endcase
      end
   end
endmodule : cpsr_top

/* File: cpsr_top_chk.sv */
// cpsr_top_chk: port-level assertions for the copper status register block.
// assumes it is bound to cpsr_top and shares its single clock.
`timescale 1ns/10ps
module cpsr_top_chk
   import cpsr_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DATA_W = 16
) (
   input wire logic i_sys_clk,
   input wire logic i_sys_rst,
   input wire logic [ADDR_W-1:0] i_addr,
   input wire logic [DATA_W-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [DATA_W-1:0] o_rdata,
   input wire logic i_phy_an_done,
   input wire logic i_phy_link,
   input wire logic i_phy_sleep,
   input wire logic i_phy_jabber,
   input wire logic [1:0] o_xover_mode,
   input wire logic o_an_enable,
   input wire logic o_irq
);
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   wire logic st_rd = i_rd && i_addr == ADDR_W'(CPSR_ADDR_STATUS);
   wire logic sw_rst = i_wr && i_addr == ADDR_W'(CPSR_ADDR_CTRL) && i_wdata[CPSR_CTRL_SW_RST];
   wire logic res_ok = !o_an_enable || i_phy_an_done;
   property p_speed; st_rd |=> o_rdata[15:14] != CPSR_SPEED_RSVD; endproperty
   a_speed: assert property (p_speed) else $error("reserved speed code read");
   // two settled cycles needed: the flag is registered
   property p_res; st_rd && res_ok && $past(res_ok) && !$past(i_wr || i_sys_rst) |=> o_rdata[11];
   endproperty
   a_res: assert property (p_res) else $error("resolved flag low");
   property p_link; st_rd && $stable(i_phy_link) |=> o_rdata[10] == $past(i_phy_link); endproperty
   a_link: assert property (p_link) else $error("live link bit wrong");
   property p_glink; st_rd && $stable(i_phy_link) |=> o_rdata[3] == o_rdata[10]; endproperty
   a_glink: assert property (p_glink) else $error("global link bit wrong");
   property p_sleep; st_rd && $stable(i_phy_sleep) ##1 1'b1 |-> o_rdata[4] == $past(i_phy_sleep);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep bit wrong");
   property p_jab; st_rd && $stable(i_phy_jabber) |=> o_rdata[0] == $past(i_phy_jabber); endproperty
   a_jab: assert property (p_jab) else $error("jabber bit wrong");
   property p_xhold; !sw_rst |=> $stable(o_xover_mode); endproperty
   a_xhold: assert property (p_xhold) else $error("crossover moved without reset");
   property p_xset; sw_rst && i_wdata[2:1] != CPSR_XMODE_RSVD |=> o_xover_mode == $past(i_wdata[2:1]);
   endproperty
   a_xset: assert property (p_xset) else $error("crossover mode not applied");
   c_page: cover property (st_rd ##1 o_rdata[CPSR_BIT_PAGE]);
   c_irq: cover property ($rose(o_irq));
   c_xmode: cover property (sw_rst ##1 $changed(o_xover_mode));
endmodule : cpsr_top_chk
bind cpsr_top cpsr_top_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
   .i_sys_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_phy_an_done,
   .i_phy_link, .i_phy_sleep, .i_phy_jabber, .o_xover_mode, .o_an_enable, .o_irq
);

/* File: tb_top.sv */
// tb_top: register-level tests of cpsr_top through its plain read/write port.
// assumes the checker binds itself to the dut.
`timescale 1ns/10ps
module tb_top
   import cpsr_pkg::*;
;
   logic i_sys_clk = 1'h0, i_sys_rst = 1'h1, i_wr = 1'h0, i_rd = 1'h0;
   logic [7:0] i_addr = 8'h00;
   logic [15:0] i_wdata = 16'h0000;
   logic [15:0] o_rdata;
   logic [1:0] i_phy_speed = 2'h0;
   logic i_phy_duplex = 1'h0, i_phy_an_done = 1'h0, i_phy_page_rx = 1'h0, i_phy_link = 1'h0;
   logic i_phy_tx_pause = 1'h0, i_phy_rx_pause = 1'h0, i_phy_auto_mdix = 1'h1;
   logic i_phy_sleep = 1'h0, i_phy_pol_rev = 1'h0, i_phy_jabber = 1'h0;
   logic [1:0] o_xover_mode;
   logic o_pol_rev_dis, o_an_enable, o_irq;
   int err_total = 0;
   int compares = 0;
   int cycles = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   cpsr_top dut (
      .i_sys_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_phy_speed,
      .i_phy_duplex, .i_phy_an_done, .i_phy_page_rx, .i_phy_link, .i_phy_tx_pause,
      .i_phy_rx_pause, .i_phy_auto_mdix, .i_phy_sleep, .i_phy_pol_rev, .i_phy_jabber,
      .o_xover_mode, .o_pol_rev_dis, .o_an_enable, .o_irq
   );
   task automatic finish_test;
      $display("compares=%0d mismatches=%0d", compares, err_total);
      if (err_total == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : finish_test
   always @(posedge i_sys_clk) begin
      cycles++;
      if (cycles == 2000) begin
         err_total++;
         finish_test();
      end
   end
   task automatic chk(input logic [15:0] s, input logic [15:0] e);
      compares++;
      if (s !== e) begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // ends on a falling edge so outputs launched by the write have settled
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_sys_clk);
      i_wr <= 1'h0;
      @(negedge i_sys_clk);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic pg, output logic [15:0] v);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'h1;
      i_phy_page_rx <= pg;
      @(posedge i_sys_clk);
      i_rd <= 1'h0;
      i_phy_page_rx <= 1'h0;
      @(negedge i_sys_clk);
      v = o_rdata;
   endtask : rd
   task automatic rc(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, 1'h0, v);
      chk(v, e);
   endtask : rc
   initial begin
      logic [15:0] v;
      logic [1:0] x;
      repeat (8) @(posedge i_sys_clk);
      i_sys_rst <= 1'h0;
      rc(CPSR_ADDR_STATUS, 16'h8040);
      chk({14'h0000, o_pol_rev_dis, o_an_enable}, 16'h0001);
      rc(CPSR_ADDR_CTRL, {11'h000, CPSR_CTRL_RST});
      wr(CPSR_ADDR_STATUS, 16'hFFFF);
      rc(CPSR_ADDR_STATUS, 16'h8040);
      $display("reset test done");
      @(posedge i_sys_clk);
      i_phy_an_done <= 1'h1;
      i_phy_duplex <= 1'h1;
      i_phy_tx_pause <= 1'h1;
      for (int s = 0; s < 4; s++) begin
         @(posedge i_sys_clk);
         i_phy_speed <= 2'(s);
         rc(CPSR_ADDR_STATUS, {(s == 3) ? CPSR_SPEED_1000 : 2'(s), 6'h2A, 8'h40});
      end
      @(posedge i_sys_clk);
      i_phy_an_done <= 1'h0;
      @(posedge i_sys_clk);
      i_phy_speed <= CPSR_SPEED_100;
      rc(CPSR_ADDR_STATUS, 16'hA240);
      wr(CPSR_ADDR_CTRL, 16'h0006);
      rc(CPSR_ADDR_STATUS, 16'h6A40);
      $display("speed test done");
      @(posedge i_sys_clk);
      i_phy_link <= 1'h1;
      i_phy_sleep <= 1'h1;
      i_phy_jabber <= 1'h1;
      i_phy_pol_rev <= 1'h1;
      rc(CPSR_ADDR_STATUS, 16'h6E5B);
      wr(CPSR_ADDR_CTRL, 16'h0007);
      chk({14'h0000, o_pol_rev_dis, o_an_enable}, 16'h0002);
      @(posedge i_sys_clk);
      i_phy_speed <= CPSR_SPEED_10;
      rc(CPSR_ADDR_STATUS, 16'h2E59);
      $display("live test done");
      chk({15'h0000, o_irq}, 16'h0000);
      rc(CPSR_ADDR_IRQ_STAT, 16'h0006);
      wr(CPSR_ADDR_IRQ_STAT, 16'h0002);
      rc(CPSR_ADDR_IRQ_STAT, 16'h0004);
      wr(CPSR_ADDR_IRQ_MASK, 16'h0004);
      rc(CPSR_ADDR_IRQ_MASK, 16'h0004);
      chk({15'h0000, o_irq}, 16'h0001);
      wr(CPSR_ADDR_IRQ_STAT, 16'h0004);
      rc(CPSR_ADDR_IRQ_STAT, 16'h0000);
      chk({15'h0000, o_irq}, 16'h0000);
      $display("irq test done");
      @(posedge i_sys_clk);
      i_phy_auto_mdix <= 1'h0;
      for (int m = 0; m < 4; m++) begin
         x = o_xover_mode;
         wr(CPSR_ADDR_CTRL, 16'(m * 2 + 1));
         chk({14'h0000, o_xover_mode}, {14'h0000, x});
         wr(CPSR_ADDR_CTRL, 16'(m * 2 + 17));
         chk({14'h0000, o_xover_mode}, (m == 2) ? 16'h0003 : 16'(m));
         rc(CPSR_ADDR_STATUS, {8'h2E, 1'h0, m == 1, 6'h19});
      end
      $display("crossover test done");
      rd(8'h00, 1'h1, v);
      chk(v, 16'h0000);
      rc(CPSR_ADDR_STATUS, 16'h3E19);
      rc(CPSR_ADDR_STATUS, 16'h2E19);
      rd(CPSR_ADDR_STATUS, 1'h1, v);
      chk(v, 16'h2E19);
      rc(CPSR_ADDR_STATUS, 16'h3E19);
      $display("page test done");
      finish_test();
   end
endmodule : tb_top
